// ===== logic/bmrf_core.sv
// banked mode register file with status words
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`include "bmrf_params.svh"
// Behaviour
// - 31 gprs plus 6 status words stored
// - sixteen registers visible, chosen by mode
// - seven modes; non-user modes privileged
// - registers zero to seven shared always
// - fast mode banks registers eight-twelve
// - each exception mode banks sp, lr
// - system mode uses user registers, privileged
// - index fifteen reads program counter
// - status word flags, disables, state, mode
// - five saved status words, one per exception mode
// - exception saves return address, status word
// - return restores status word and pc
// - five exception types, simultaneous prioritised
// - instruction width follows instruction state bit
// - condition code gates execution
// - three-stage pipeline outside this block
// - mode changes by software or exception
module bmrf_core #(
  parameter int unsigned ADDR_W = 4,
  parameter int unsigned DATA_W = 32
) (
  input  wire logic             mclk,
  input  wire logic             arst_n,
  input  wire logic [3:0]       rd_a_idx,
  input  wire logic [3:0]       rd_b_idx,
  output logic      [31:0]      rd_a_data,
  output logic      [31:0]      rd_b_data,
  input  wire bmrf_pkg::bmrf_wr_t wr,
  input  wire logic             pc_wen,
  input  wire logic [31:0]      pc_wdata,
  input  wire logic             exc_fiq,
  input  wire logic             exc_irq,
  input  wire logic             exc_abt,
  input  wire logic             exc_und,
  input  wire logic             exc_trap,
  input  wire logic [31:0]      exc_ret_addr,
  input  wire logic [31:0]      exc_vector,
  input  wire logic [3:0]       cond_field,
  output logic                  cond_pass,
  output logic      [31:0]      pc,
  output logic      [31:0]      cur_status_word,
  output logic      [31:0]      saved_status_word,
  output logic                  privileged,
  output logic                  mode_invalid,
  output logic                  insn_wide,
  output logic      [2:0]       exc_taken
);
  import bmrf_pkg::*;

  // elaboration check: ports are fixed at 4-bit register index and 32-bit data
  if (ADDR_W != 4 || DATA_W != 32)
  begin : g_bad_param
    $error("bmrf_core serves only 4-bit index and 32-bit data");
  end

  // =========================================================
  // overview
  // storage layout, 31 general registers in all:
  //   gpr_u  : r0..r14 as seen in user and system mode
  //   fiq_hi : fast mode copies of r8..r12
  //   sp_b   : one stack pointer per exception mode
  //   lr_b   : one link register per exception mode
  //   pc     : index fifteen, shared by every mode
  // status words, six in all:
  //   cur_sw : the current status word
  //   sav_sw : one saved word per exception mode
  // bank slots 0..4 follow the bank enum minus one:
  //   fast, normal, supervisor, abort, undefined
  // per edge priority:
  //   exception entry, then exception return, then writes
  // exception priority:
  //   abort, fast, normal, undefined, software trap
  // a trap enters supervisor mode; entry always masks
  // normal interrupts, fast entry masks fast ones too
  // reads are combinational on registered state, so the
  // decode stage of the pipeline sees a write of the
  // execute stage one edge later
  // invalid mode codes read and write the user bank and
  // report themselves on mode_invalid

  // =========================================================
  // helpers
  // mode code to bank, invalid codes fall back to user bank
  function automatic bmrf_bank_t bank_of(input logic [4:0] m);
    unique case (m)
      `BMRF_MODE_FIQ: bank_of = BK_FIQ;
      `BMRF_MODE_IRQ: bank_of = BK_IRQ;
      `BMRF_MODE_SVC: bank_of = BK_SVC;
      `BMRF_MODE_ABT: bank_of = BK_ABT;
      `BMRF_MODE_UND: bank_of = BK_UND;
      default:        bank_of = BK_USR;
    endcase
  endfunction

  // seven legal mode codes
  function automatic logic mode_ok(input logic [4:0] m);
    mode_ok = (m == `BMRF_MODE_USR) || (m == `BMRF_MODE_FIQ) || (m == `BMRF_MODE_IRQ)
           || (m == `BMRF_MODE_SVC) || (m == `BMRF_MODE_ABT) || (m == `BMRF_MODE_UND)
           || (m == `BMRF_MODE_SYS);
  endfunction

  // banked slot index 0..4 of an exception bank
  function automatic logic [2:0] slot(input bmrf_bank_t b);
    slot = 3'(b) - 3'h1;
  endfunction

  // visible register read through the mode bank
  function automatic logic [31:0] rd_reg(input bmrf_state_t s, input logic [3:0] i,
                                         input bmrf_bank_t b);
    if (i == `BMRF_IDX_PC)
      rd_reg = s.pc;
    else if (i < 4'h8)
      rd_reg = s.gpr_u[i];
    else if (i <= 4'hc)
      rd_reg = (b == BK_FIQ) ? s.fiq_hi[i - 4'h8] : s.gpr_u[i];
    else if (b == BK_USR)
      rd_reg = s.gpr_u[i];
    else if (i == `BMRF_IDX_SP)
      rd_reg = s.sp_b[slot(b)];
    else
      rd_reg = s.lr_b[slot(b)];
  endfunction

  // condition code evaluation against the flags
  function automatic logic cond_ok(input logic [3:0] c, input logic [31:0] sw);
    logic n;
    logic z;
    logic cf;
    logic v;
    n  = sw[`BMRF_SW_N];
    z  = sw[`BMRF_SW_Z];
    cf = sw[`BMRF_SW_C];
    v  = sw[`BMRF_SW_V];
    unique case (c)
      4'h0: cond_ok = z;
      4'h1: cond_ok = !z;
      4'h2: cond_ok = cf;
      4'h3: cond_ok = !cf;
      4'h4: cond_ok = n;
      4'h5: cond_ok = !n;
      4'h6: cond_ok = v;
      4'h7: cond_ok = !v;
      4'h8: cond_ok = cf && !z;
      4'h9: cond_ok = !cf || z;
      4'ha: cond_ok = n == v;
      4'hb: cond_ok = n != v;
      4'hc: cond_ok = !z && (n == v);
      4'hd: cond_ok = z || (n != v);
      4'he: cond_ok = 1'b1;
      4'hf: cond_ok = 1'b0;
    endcase
  endfunction

  // =========================================================
  // state
  bmrf_state_t st_q;
  bmrf_state_t st_d;
  bmrf_bank_t  bank;
  bmrf_exc_t   exc_sel;
  logic [4:0]  mode;
  logic [4:0]  tgt_mode;

  assign mode = st_q.cur_sw[`BMRF_SW_MODE_HI:0];
  assign bank = bank_of(mode);

  // prioritise simultaneous exceptions
  always_comb
  begin
    exc_sel  = EX_NONE;
    tgt_mode = mode;
    if (exc_abt)
    begin
      exc_sel  = EX_ABT;
      tgt_mode = `BMRF_MODE_ABT;
    end
    else if (exc_fiq && !st_q.cur_sw[`BMRF_SW_FIQD])
    begin
      exc_sel  = EX_FIQ;
      tgt_mode = `BMRF_MODE_FIQ;
    end
    else if (exc_irq && !st_q.cur_sw[`BMRF_SW_IRQD])
    begin
      exc_sel  = EX_IRQ;
      tgt_mode = `BMRF_MODE_IRQ;
    end
    else if (exc_und)
    begin
      exc_sel  = EX_UND;
      tgt_mode = `BMRF_MODE_UND;
    end
    else if (exc_trap)
    begin
      exc_sel  = EX_TRAP;
      tgt_mode = `BMRF_MODE_SVC;
    end
  end

  // next state: writes, exception entry, exception return
  always_comb
  begin
    bmrf_bank_t tb;
    st_d = st_q;
    tb   = bank_of(tgt_mode);
    if (exc_sel != EX_NONE)
    begin
      st_d.lr_b[slot(tb)]   = exc_ret_addr;
      st_d.sav_sw[slot(tb)] = st_q.cur_sw;
      st_d.cur_sw[`BMRF_SW_MODE_HI:0] = tgt_mode;
      st_d.cur_sw[`BMRF_SW_IRQD] = 1'b1;
      st_d.cur_sw[`BMRF_SW_TST]  = 1'b0;
      if (exc_sel == EX_FIQ)
        st_d.cur_sw[`BMRF_SW_FIQD] = 1'b1;
      st_d.pc = exc_vector;
    end
    else if (wr.exc_ret && bank != BK_USR)
    begin
      st_d.cur_sw = st_q.sav_sw[slot(bank)];
      st_d.pc     = rd_reg(st_q, `BMRF_IDX_LR, bank);
    end
    else
    begin
      if (pc_wen)
        st_d.pc = pc_wdata;
      if (wr.wen)
      begin
        if (wr.widx == `BMRF_IDX_PC)
          st_d.pc = wr.wdata;
        else if (wr.widx < 4'h8)
          st_d.gpr_u[wr.widx] = wr.wdata;
        else if (wr.widx <= 4'hc && bank == BK_FIQ)
          st_d.fiq_hi[wr.widx - 4'h8] = wr.wdata;
        else if (wr.widx <= 4'hc || bank == BK_USR)
          st_d.gpr_u[wr.widx] = wr.wdata;
        else if (wr.widx == `BMRF_IDX_SP)
          st_d.sp_b[slot(bank)] = wr.wdata;
        else
          st_d.lr_b[slot(bank)] = wr.wdata;
      end
      // only non-user modes, invalid mode codes included, may change control bits
      if (wr.sw_wen)
      begin
        if (mode != `BMRF_MODE_USR)
          st_d.cur_sw = wr.sw_wdata;
        else
          st_d.cur_sw[`BMRF_SW_N:`BMRF_SW_V] = wr.sw_wdata[`BMRF_SW_N:`BMRF_SW_V];
      end
      if (wr.ssw_wen && bank != BK_USR)
        st_d.sav_sw[slot(bank)] = wr.sw_wdata;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q        <= '0;
      st_q.cur_sw <= `BMRF_SW_RESET;
    end
    else
      st_q <= st_d;
  end

  // =========================================================
  // outputs
  // two operand read ports for the decode stage
  assign rd_a_data         = rd_reg(st_q, rd_a_idx, bank);
  assign rd_b_data         = rd_reg(st_q, rd_b_idx, bank);
  assign pc                = st_q.pc;
  assign cur_status_word   = st_q.cur_sw;
  assign saved_status_word = (bank == BK_USR) ? 32'h0000_0000 : st_q.sav_sw[slot(bank)];
  assign privileged        = mode_ok(mode) && mode != `BMRF_MODE_USR;
  assign mode_invalid      = !mode_ok(mode);
  assign insn_wide         = !st_q.cur_sw[`BMRF_SW_TST];
  assign cond_pass         = cond_ok(cond_field, st_q.cur_sw);
  assign exc_taken         = 3'(exc_sel);
endmodule

// ===== pkg/bmrf_params.svh
// constants of the banked mode register file
`ifndef BMRF_PARAMS_SVH
`define BMRF_PARAMS_SVH
// mode field codes (five bits)
`define BMRF_MODE_USR 5'h10
`define BMRF_MODE_FIQ 5'h11
`define BMRF_MODE_IRQ 5'h12
`define BMRF_MODE_SVC 5'h13
`define BMRF_MODE_ABT 5'h17
`define BMRF_MODE_UND 5'h1b
`define BMRF_MODE_SYS 5'h1f
// status word field positions
`define BMRF_SW_N    31
`define BMRF_SW_Z    30
`define BMRF_SW_C    29
`define BMRF_SW_V    28
`define BMRF_SW_IRQD 7
`define BMRF_SW_FIQD 6
`define BMRF_SW_TST  5
`define BMRF_SW_MODE_HI 4
// status word reset value: supervisor, both interrupts disabled
`define BMRF_SW_RESET 32'h0000_00d3
// register indices
`define BMRF_IDX_SP 4'hd
`define BMRF_IDX_LR 4'he
`define BMRF_IDX_PC 4'hf
// physical register counts
`define BMRF_NUM_GPR 31
`define BMRF_NUM_SW  6
// condition field top bit
`define BMRF_COND_HI 31
`endif

// ===== pkg/bmrf_pkg.sv
// types of the banked mode register file
package bmrf_pkg;
  typedef enum logic [2:0] {BK_USR, BK_FIQ, BK_IRQ, BK_SVC, BK_ABT, BK_UND} bmrf_bank_t;
  typedef enum logic [2:0] {EX_NONE, EX_FIQ, EX_IRQ, EX_ABT, EX_UND, EX_TRAP} bmrf_exc_t;
  typedef struct packed {
    logic        wen;
    logic [3:0]  widx;
    logic [31:0] wdata;
    logic        sw_wen;    // move to current status word
    logic        ssw_wen;   // move to saved status word
    logic [31:0] sw_wdata;
    logic        exc_ret;   // exception return
  } bmrf_wr_t;
  typedef struct packed {
    logic [14:0][31:0] gpr_u;   // user and system r0..r14
    logic [4:0][31:0]  fiq_hi;  // fast mode r8..r12
    logic [4:0][31:0]  sp_b;    // banked stack pointers
    logic [4:0][31:0]  lr_b;    // banked link registers
    logic [31:0]       cur_sw;
    logic [4:0][31:0]  sav_sw;  // banked saved words
    logic [31:0]       pc;
  } bmrf_state_t;
endpackage

// ===== tb/bmrf_props.sv
// assertion checker of the banked mode register file
`include "bmrf_params.svh"
module bmrf_props (
  input wire logic               mclk,
  input wire logic               arst_n,
  input wire logic [3:0]         rd_a_idx,
  input wire logic [31:0]        rd_a_data,
  input wire bmrf_pkg::bmrf_wr_t wr,
  input wire logic [31:0]        exc_vector,
  input wire logic [3:0]         cond_field,
  input wire logic               cond_pass,
  input wire logic [31:0]        pc,
  input wire logic [31:0]        cur_status_word,
  input wire logic [31:0]        saved_status_word,
  input wire logic               privileged,
  input wire logic               mode_invalid,
  input wire logic               insn_wide,
  input wire logic [2:0]         exc_taken
);
  timeunit 1ns;
  timeprecision 100ps;
  import bmrf_pkg::*;
  logic [4:0] md;
  // mode field of the current word
  assign md = cur_status_word[4:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ==========
  // mode decode and status word
  a_reset_word: assert property ($rose(arst_n) |-> cur_status_word == `BMRF_SW_RESET)
    else $error("status word after reset wrong");
  a_user_rights: assert property (md == `BMRF_MODE_USR |-> !privileged)
    else $error("user mode privileged");
  a_system_rights: assert property (md == `BMRF_MODE_SYS |-> privileged)
    else $error("system mode not privileged");
  a_mode_check: assert property (mode_invalid == !(md inside {5'h10, 5'h11, 5'h12,
    5'h13, 5'h17, 5'h1b, 5'h1f})) else $error("mode validity wrong");
  a_insn_width: assert property (insn_wide != cur_status_word[`BMRF_SW_TST])
    else $error("instruction width wrong");
  a_cond_always: assert property (cond_field == 4'he |-> cond_pass)
    else $error("always condition failed");
  // ==========
  // program counter and exceptions
  a_pc_visible: assert property (rd_a_idx == `BMRF_IDX_PC |-> rd_a_data == pc)
    else $error("index fifteen not pc");
  a_irq_entry: assert property (exc_taken == EX_IRQ |=> md == `BMRF_MODE_IRQ
    && cur_status_word[7] && pc == $past(exc_vector)
    && saved_status_word == $past(cur_status_word)) else $error("irq entry wrong");
  a_ret_restore: assert property (wr.exc_ret && exc_taken == EX_NONE
    && md inside {5'h11, 5'h12, 5'h13, 5'h17, 5'h1b}
    |=> cur_status_word == $past(saved_status_word)) else $error("return restore wrong");
  c_irq: cover property (exc_taken == EX_IRQ);
  c_fiq: cover property (exc_taken == EX_FIQ);
  c_ret: cover property (wr.exc_ret && md == `BMRF_MODE_FIQ);
endmodule
bind bmrf_core bmrf_props bmrf_props_inst (.mclk, .arst_n, .rd_a_idx, .rd_a_data, .wr,
  .exc_vector, .cond_field, .cond_pass, .pc, .cur_status_word, .saved_status_word,
  .privileged, .mode_invalid, .insn_wide, .exc_taken);

// ===== tb/tb_top.sv
// self-checking bench of the banked mode register file
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import bmrf_pkg::*;
  logic              mclk = 1'b0;
  logic              arst_n = 1'b0;
  logic [3:0]        rd_a_idx = 4'h0;
  logic [3:0]        cond = 4'h0;
  logic [4:0]        req = 5'h0;
  logic [31:0]       ret_a = 32'h0;
  logic [31:0]       vec = 32'h0;
  bmrf_wr_t          wr = '0;
  logic [31:0]       rd_a_data, rdb, pc, sw, ssw;
  logic              cp, prv, inv, wide;
  logic              pcw = 1'b0;
  logic [31:0]       pcd = 32'h0;
  logic [2:0]        tkn;
  int                fail_count = 0;
  int                compares = 0;
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  bmrf_core bmrf_core_inst (.mclk, .arst_n, .rd_a_idx, .rd_b_idx(4'hf), .rd_a_data,
    .rd_b_data(rdb), .wr, .pc_wen(pcw), .pc_wdata(pcd), .exc_fiq(req[4]), .exc_irq(req[3]),
    .exc_abt(req[2]), .exc_und(req[1]), .exc_trap(req[0]), .exc_ret_addr(ret_a),
    .exc_vector(vec), .cond_field(cond), .cond_pass(cp), .pc, .cur_status_word(sw),
    .saved_status_word(ssw), .privileged(prv), .mode_invalid(inv), .insn_wide(wide),
    .exc_taken(tkn));
  // ==========
  // drivers and comparison
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // k: 1 register write, 2 status write, 3 exception return
  task automatic put(input logic [1:0] k, input logic [3:0] i, input logic [31:0] d);
    bmrf_wr_t w;
    w = '0;
    w.wen = (k == 2'h1);
    w.widx = i;
    w.wdata = d;
    w.sw_wen = (k == 2'h2);
    w.sw_wdata = d;
    w.exc_ret = (k == 2'h3);
    @(posedge mclk);
    wr <= w;
    @(posedge mclk);
    wr <= '0;
    @(negedge mclk);
  endtask
  task automatic rchk(input logic [3:0] i, input logic [31:0] e);
    @(posedge mclk);
    rd_a_idx <= i;
    @(negedge mclk);
    chk("register", e, rd_a_data);
  endtask
  // request bits: fast, normal, abort, undefined, trap
  task automatic exc(input logic [4:0] r, input logic [2:0] e);
    @(posedge mclk);
    req <= r;
    ret_a <= 32'h100 + {25'h0, r, 2'h0};
    vec <= 32'h200 + {25'h0, r, 2'h0};
    @(negedge mclk);
    chk("taken", {29'h0, e}, {29'h0, tkn});
    @(posedge mclk);
    req <= 5'h0;
    @(negedge mclk);
  endtask
  // ==========
  // scenarios
  task automatic t_bank();
    chk("word", 32'h0000_00d3, sw);
    put(2'h2, 4'h0, 32'h0000_0013);
    put(2'h1, 4'h3, 32'h0000_aaaa);
    put(2'h1, 4'h8, 32'h0000_bbbb);
    put(2'h1, 4'hd, 32'h0000_cccc);
    exc(5'h10, EX_FIQ);
    chk("mode", 32'h11, {27'h0, sw[4:0]});
    chk("saved", 32'h13, ssw);
    chk("pc", 32'h240, pc);
    rchk(4'h3, 32'h0000_aaaa);
    rchk(4'h8, 32'h0);
    rchk(4'hd, 32'h0);
    rchk(4'he, 32'h140);
    put(2'h1, 4'h8, 32'h0000_dddd);
    put(2'h3, 4'h0, 32'h0);
    chk("word", 32'h13, sw);
    chk("pc", 32'h140, pc);
    rchk(4'h8, 32'h0000_bbbb);
    rchk(4'hd, 32'h0000_cccc);
    exc(5'h08, EX_IRQ);
    chk("word", 32'h92, sw);
    rchk(4'he, 32'h120);
    rchk(4'hf, 32'h220);
    chk("port b", 32'h220, rdb);
    chk("wide", 32'h1, {31'h0, wide});
    $display("bank test done");
  endtask
  task automatic t_sys();
    put(2'h3, 4'h0, 32'h0);
    put(2'h2, 4'h0, 32'h0000_009f);
    exc(5'h08, EX_NONE);
    chk("word", 32'h9f, sw);
    put(2'h1, 4'hd, 32'h0000_eeee);
    put(2'h2, 4'h0, 32'h0000_0010);
    rchk(4'hd, 32'h0000_eeee);
    chk("rights", 32'h0, {31'h0, prv});
    put(2'h2, 4'h0, 32'hf000_001f);
    put(2'h3, 4'h0, 32'h0);
    chk("word", 32'hf000_0010, sw);
    @(posedge mclk);
    cond <= 4'h1;
    @(negedge mclk);
    chk("cond", 32'h0, {31'h0, cp});
    @(posedge mclk);
    pcw <= 1'b1;
    pcd <= 32'h300;
    @(posedge mclk);
    pcw <= 1'b0;
    @(negedge mclk);
    chk("pc", 32'h300, pc);
    $display("system test done");
  endtask
  task automatic t_prio();
    exc(5'h07, EX_ABT);
    chk("saved", 32'hf000_0010, ssw);
    exc(5'h01, EX_TRAP);
    chk("mode", 32'h13, {27'h0, sw[4:0]});
    put(2'h2, 4'h0, 32'h0000_0015);
    chk("invalid", 32'h1, {31'h0, inv});
    chk("rights", 32'h0, {31'h0, prv});
    $display("priority test done");
  endtask
  task automatic complete_run();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    @(negedge mclk);
    t_bank();
    t_sys();
    t_prio();
    complete_run();
  end
  // watchdog
  initial
  begin
    #5000;
    fail_count++;
    complete_run();
  end
endmodule
